/* rtl/bsi_defs.svh */
// Offsets, field positions and reset values of the static bus interface.
// Assumes inclusion by bare name from rtl and testbench files of this block.
`ifndef BSI_DEFS_SVH
`define BSI_DEFS_SVH

`define BSI_REG_BCR 8'h00
`define BSI_REG_AREA 8'h04
`define BSI_REG_WCA 8'h08
`define BSI_REG_WCB 8'h0c
`define BSI_REG_IBC 8'h10
`define BSI_REG_STAT 8'h14

`define BSI_WPE_BIT 0
`define BSI_IBC_BIT 0
`define BSI_F_WIDE 0
`define BSI_F_THREE 8
`define BSI_F_MUX 16
`define BSI_F_LITTLE 24

`define BSI_AREA_RST 32'h0000ff00
`define BSI_WC_RST 16'h7777
`define BSI_WC_PITCH 4
`define BSI_AREA_MSB 23
`define BSI_AREA_LSB 21

`define BSI_RESP_OK 2'b00
`define BSI_RESP_ERR 2'b10

`endif

/* rtl/bsi_pkg.sv */
// Types shared by the static bus interface modules.
// Assumes nothing of its surroundings.
package bsi_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG
    } bsi_size_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        FIRST_STATE,
        SECOND_STATE,
        WAIT_STATE,
        PIN_WAIT_STATE,
        THIRD_STATE
    } bsi_state_t;
endpackage

/* rtl/bsi_lane_if.sv */
// Lane plan request and answer between sequencer and lane planner.
// Assumes both ends on one clock; purely combinational path.
`timescale 1ns/1ns
interface bsi_lane_if;
    bsi_pkg::bsi_size_t size;
    logic a0;
    logic wide;
    logic little;
    logic [1:0] off;
    logic two;
    logic hi_en;
    logic lo_en;
    logic [1:0] hi_idx;
    logic [1:0] lo_idx;
    logic last;
    logic [1:0] step;

    modport planner(input size, a0, wide, little, off,
                    output two, hi_en, lo_en, hi_idx, lo_idx, last, step);
    modport user(output size, a0, wide, little, off,
                 input two, hi_en, lo_en, hi_idx, lo_idx, last, step);
endinterface

/* rtl/bsi_lane_plan.sv */
// Byte lane planner: for the current byte offset of an access, picks
// the lanes, the data byte on each lane and whether this is the last cycle.
// Assumes off only ever lands on a byte the previous cycles left over.
`timescale 1ns/1ns
module bsi_lane_plan (
    // Plan
    bsi_lane_if.planner lp
);
    logic [2:0] nb;
    wire even = ~(lp.a0 ^ lp.off[0]);
    wire [2:0] left = nb - {1'b0, lp.off};
    wire first_hi = lp.wide & (even ^ lp.little);
    wire [1:0] idx_a = lp.little ? lp.off : 2'(nb - 3'd1 - {1'b0, lp.off});
    wire [1:0] idx_b = lp.little ? 2'(lp.off + 2'd1) : 2'(nb - 3'd2 - {1'b0, lp.off});

    always_comb begin
        case (lp.size)
            bsi_pkg::SZ_BYTE: nb = 3'd1;
            bsi_pkg::SZ_WORD: nb = 3'd2;
            default: nb = 3'd4;
        endcase
    end

    // Word cycle only on an even address with two bytes left
    assign lp.two = lp.wide & even & (left >= 3'd2);
    // Narrow space never touches the upper lane
    assign lp.hi_en = lp.two | first_hi;
    assign lp.lo_en = lp.two | ~first_hi;
    assign lp.hi_idx = first_hi ? idx_a : idx_b;
    assign lp.lo_idx = first_hi ? idx_b : idx_a;
    assign lp.step = lp.two ? 2'd2 : 2'd1;
    assign lp.last = ({1'b0, lp.off} + {1'b0, lp.step}) == nb;
endmodule

/* rtl/bsi_top.sv */
// Static memory bus interface: internal request port in, external
// ROM/SRAM pins out, configuration over AXI4-Lite.
// Assumes pins outside clk domain; request port and AXI on clk.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "bsi_defs.svh"
module bsi_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Internal master request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [23:0] req_addr,
    input wire bsi_pkg::bsi_size_t req_size,
    input wire logic req_write,
    input wire logic [31:0] req_wdata,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    // External bus
    output logic [23:0] ext_addr,
    output logic [15:0] data_o,
    output logic data_oe,
    input wire logic [15:0] data_i,
    output logic bus_cycle_start_n,
    output logic address_strobe_n,
    output logic address_hold_n,
    output logic read_n,
    output logic rd_wr,
    output logic upper_byte_write_n,
    output logic lower_byte_write_n,
    output logic [7:0] area_select_n,
    input wire logic wait_n
);
    bsi_pkg::bsi_state_t st_q, st_d;
    logic [23:0] addr_q;
    bsi_pkg::bsi_size_t size_q;
    logic wr_q;
    logic [31:0] wdat_q;
    logic [31:0] rdat_q;
    logic [1:0] off_q;
    logic [2:0] wcnt_q;
    logic done_q, last_q;
    logic cap_q, cap_hi_q, cap_lo_q;
    logic [1:0] cap_hidx_q, cap_lidx_q;
    logic [15:0] dout_q;
    logic [23:0] ea_q;
    logic [15:0] din_s1_q, din_s2_q;
    logic wait_s1_q, wait_s2_q;
    logic [31:0] bcr_q, area_q;
    logic [15:0] wca_q, wcb_q;
    logic ibc_q;
    logic aw_q, w_q, bv_q, rv_q;
    logic [7:0] awa_q;
    logic [31:0] awd_q;
    logic [3:0] aws_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rd_q;

    bsi_lane_if lp();
    bsi_lane_plan u_plan (
        .lp(lp)
    );

    // Area decode and per-area configuration
    wire [2:0] area = addr_q[`BSI_AREA_MSB:`BSI_AREA_LSB];
    wire wide = area_q[`BSI_F_WIDE + area];
    wire three = area_q[`BSI_F_THREE + area];
    wire mux = area_q[`BSI_F_MUX + area];
    wire little = area_q[`BSI_F_LITTLE + area];
    wire [31:0] wc_all = {wca_q, wcb_q};
    wire [2:0] wc = wc_all[area * `BSI_WC_PITCH +: 3];
    // Two enable bits, BCR and IBC, serve every three-state area
    wire pin_en = three & bcr_q[`BSI_WPE_BIT] & ibc_q;
    wire stall = pin_en & ~wait_s2_q;

    assign lp.size = size_q;
    assign lp.a0 = addr_q[0];
    assign lp.wide = wide;
    assign lp.little = little;
    assign lp.off = off_q;

    wire in_bus = st_q != bsi_pkg::ST_IDLE;
    wire strobe = st_q != bsi_pkg::ST_IDLE && st_q != bsi_pkg::FIRST_STATE;
    wire end_cyc = (st_q == bsi_pkg::SECOND_STATE && !three) ||
                   st_q == bsi_pkg::THIRD_STATE;

    // Sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            bsi_pkg::ST_IDLE: begin
                if (req_valid) begin
                    st_d = bsi_pkg::FIRST_STATE;
                end
            end
            bsi_pkg::FIRST_STATE: st_d = bsi_pkg::SECOND_STATE;
            bsi_pkg::SECOND_STATE: begin
                if (!three) begin
                    // Two-state areas never stretch
                    st_d = lp.last ? bsi_pkg::ST_IDLE : bsi_pkg::FIRST_STATE;
                end else if (wcnt_q != 3'h0) begin
                    st_d = bsi_pkg::WAIT_STATE;
                end else if (stall) begin
                    st_d = bsi_pkg::PIN_WAIT_STATE;
                end else begin
                    st_d = bsi_pkg::THIRD_STATE;
                end
            end
            bsi_pkg::WAIT_STATE: begin
                if (wcnt_q == 3'h1) begin
                    st_d = stall ? bsi_pkg::PIN_WAIT_STATE : bsi_pkg::THIRD_STATE;
                end
            end
            bsi_pkg::PIN_WAIT_STATE: begin
                if (!stall) begin
                    st_d = bsi_pkg::THIRD_STATE;
                end
            end
            bsi_pkg::THIRD_STATE: begin
                st_d = lp.last ? bsi_pkg::ST_IDLE : bsi_pkg::FIRST_STATE;
            end
            default: st_d = bsi_pkg::ST_IDLE;
        endcase
    end

    // Held off while the last read lanes are still landing
    assign req_ready = st_q == bsi_pkg::ST_IDLE && !last_q;
    wire take = req_valid && req_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= bsi_pkg::ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= 24'h0;
            size_q <= bsi_pkg::SZ_BYTE;
            wr_q <= 1'b0;
            wdat_q <= 32'h0;
        end else if (take) begin
            addr_q <= req_addr;
            size_q <= req_size;
            wr_q <= req_write;
            wdat_q <= req_wdata;
        end
    end

    // Offset walks the bytes in address order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_q <= 2'h0;
        end else if (take) begin
            off_q <= 2'h0;
        end else if (end_cyc) begin
            off_q <= 2'(off_q + lp.step);
        end
    end

    // Programmed wait count loaded per bus cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wcnt_q <= 3'h0;
        end else if (st_q == bsi_pkg::FIRST_STATE) begin
            wcnt_q <= three ? wc : 3'h0;
        end else if (st_q == bsi_pkg::WAIT_STATE) begin
            wcnt_q <= wcnt_q - 3'h1;
        end
    end

    // Address latched on entry to first state, write data at its end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ea_q <= 24'h0;
            dout_q <= 16'h0;
        end else if (st_q == bsi_pkg::FIRST_STATE) begin
            dout_q <= {wdat_q[lp.hi_idx * 8 +: 8], wdat_q[lp.lo_idx * 8 +: 8]};
        end else if (st_d == bsi_pkg::FIRST_STATE) begin
            ea_q <= take ? req_addr : 24'(addr_q + {22'h0, 2'(off_q + lp.step)});
        end
    end

    // Pins pass two flops; data is sampled late but held stable by strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            din_s1_q <= 16'h0;
            din_s2_q <= 16'h0;
            wait_s1_q <= 1'b1;
            wait_s2_q <= 1'b1;
        end else begin
            din_s1_q <= data_i;
            din_s2_q <= din_s1_q;
            wait_s1_q <= wait_n;
            wait_s2_q <= wait_s1_q;
        end
    end

    // Synced pin data trails by two clocks, so lanes are kept for one more edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_q <= 1'b0;
            cap_hi_q <= 1'b0;
            cap_lo_q <= 1'b0;
            cap_hidx_q <= 2'h0;
            cap_lidx_q <= 2'h0;
        end else begin
            cap_q <= end_cyc && !wr_q;
            cap_hi_q <= lp.hi_en;
            cap_lo_q <= lp.lo_en;
            cap_hidx_q <= lp.hi_idx;
            cap_lidx_q <= lp.lo_idx;
        end
    end

    // Read bytes land at their data positions
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdat_q <= 32'h0;
        end else if (take) begin
            rdat_q <= 32'h0;
        end else if (cap_q) begin
            if (cap_hi_q) begin
                rdat_q[cap_hidx_q * 8 +: 8] <= din_s2_q[15:8];
            end
            if (cap_lo_q) begin
                rdat_q[cap_lidx_q * 8 +: 8] <= din_s2_q[7:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            last_q <= end_cyc && lp.last;
            done_q <= last_q;
        end
    end

    assign resp_valid = done_q;
    assign resp_rdata = rdat_q;

    // Pin decode
    assign ext_addr = ea_q;
    assign data_o = dout_q;
    assign data_oe = wr_q && strobe;
    assign bus_cycle_start_n = st_q != bsi_pkg::FIRST_STATE;
    assign address_strobe_n = !(in_bus && !mux);
    assign address_hold_n = !(in_bus && mux);
    assign read_n = !(strobe && !wr_q);
    assign rd_wr = !(in_bus && wr_q);
    assign upper_byte_write_n = !(strobe && wr_q && lp.hi_en);
    assign lower_byte_write_n = !(strobe && wr_q && lp.lo_en);
    assign area_select_n = ~(in_bus ? (8'h01 << area) : 8'h00);

    // Register write path
    wire do_wr = aw_q && w_q && !bv_q;
    wire wr_hit = awa_q == `BSI_REG_BCR || awa_q == `BSI_REG_AREA ||
                  awa_q == `BSI_REG_WCA || awa_q == `BSI_REG_WCB ||
                  awa_q == `BSI_REG_IBC || awa_q == `BSI_REG_STAT;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i * 8 +: 8] = n[i * 8 +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] wca_m = merge({16'h0, wca_q}, awd_q, aws_q);
    wire [31:0] wcb_m = merge({16'h0, wcb_q}, awd_q, aws_q);
    wire [31:0] bcr_m = merge(bcr_q, awd_q, aws_q);
    wire [31:0] ibc_m = merge({31'h0, ibc_q}, awd_q, aws_q);

    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h0;
            awd_q <= 32'h0;
            aws_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_q) begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_q) begin
                w_q <= 1'b1;
                awd_q <= s_axi_wdata;
                aws_q <= s_axi_wstrb;
            end else if (do_wr) begin
                w_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bv_q <= 1'b0;
            bresp_q <= `BSI_RESP_OK;
        end else if (do_wr) begin
            bv_q <= 1'b1;
            bresp_q <= wr_hit ? `BSI_RESP_OK : `BSI_RESP_ERR;
        end else if (s_axi_bready) begin
            bv_q <= 1'b0;
        end
    end

    // Reset leaves every area three-state, seven waits, pin off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bcr_q <= 32'h0;
            area_q <= `BSI_AREA_RST;
            wca_q <= `BSI_WC_RST;
            wcb_q <= `BSI_WC_RST;
            ibc_q <= 1'b0;
        end else if (do_wr) begin
            case (awa_q)
                `BSI_REG_BCR: bcr_q <= {31'h0, bcr_m[`BSI_WPE_BIT]};
                `BSI_REG_AREA: area_q <= merge(area_q, awd_q, aws_q);
                `BSI_REG_WCA: wca_q <= wca_m[15:0];
                `BSI_REG_WCB: wcb_q <= wcb_m[15:0];
                `BSI_REG_IBC: ibc_q <= ibc_m[`BSI_IBC_BIT];
                default: ibc_q <= ibc_q;
            endcase
        end
    end

    // Register read path; status shows the live bus state
    wire [31:0] stat = {24'h0, 1'b0, area, 1'b0, st_q};
    wire ar_take = s_axi_arvalid && !rv_q;

    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rresp_q <= `BSI_RESP_OK;
        end else if (ar_take) begin
            rv_q <= 1'b1;
            rresp_q <= `BSI_RESP_OK;
            case (s_axi_araddr)
                `BSI_REG_BCR: rd_q <= bcr_q;
                `BSI_REG_AREA: rd_q <= area_q;
                `BSI_REG_WCA: rd_q <= {16'h0, wca_q};
                `BSI_REG_WCB: rd_q <= {16'h0, wcb_q};
                `BSI_REG_IBC: rd_q <= {31'h0, ibc_q};
                `BSI_REG_STAT: rd_q <= stat;
                default: begin
                    rd_q <= 32'h0;
                    rresp_q <= `BSI_RESP_ERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rv_q <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_prog_waits;
        (st_q == bsi_pkg::WAIT_STATE) [*7];
    endsequence

    a_cycle_start_first: assert property (
        !bus_cycle_start_n |-> st_q == bsi_pkg::FIRST_STATE ##1 !bus_cycle_start_n == 1'b0)
        else $error("cycle start not a single first state");
    a_two_state_len: assert property (
        (st_q == bsi_pkg::SECOND_STATE && !three) |=>
        (st_q == bsi_pkg::ST_IDLE || st_q == bsi_pkg::FIRST_STATE))
        else $error("two-state cycle stretched");
    a_seven_waits: assert property (
        (st_q == bsi_pkg::SECOND_STATE && three && wcnt_q == 3'h7) |=>
        s_prog_waits ##1 (st_q == bsi_pkg::THIRD_STATE || st_q == bsi_pkg::PIN_WAIT_STATE))
        else $error("programmed wait count wrong");
    a_pin_wait_gate: assert property (
        st_q == bsi_pkg::PIN_WAIT_STATE |-> pin_en && three)
        else $error("pin wait without enable");
    a_pin_wait_hold: assert property (
        (st_q == bsi_pkg::PIN_WAIT_STATE && !wait_s2_q) |=> st_q == bsi_pkg::PIN_WAIT_STATE)
        else $error("pin wait left while pin low");
    a_read_strobe_dir: assert property (
        !read_n |-> rd_wr && !data_oe && !wr_q)
        else $error("read strobe during write");
    a_narrow_lane: assert property (
        !wide && in_bus |-> upper_byte_write_n && !lp.two)
        else $error("upper lane used in narrow area");
    a_one_select: assert property (
        in_bus |-> $onehot(~area_select_n) && !area_select_n[area])
        else $error("wrong area select");
    a_strobe_addr: assert property (
        !address_strobe_n |-> in_bus && !mux && address_hold_n)
        else $error("address strobe outside cycle");
    a_resp_after_end: assert property (
        (end_cyc && lp.last) |=> ##1 resp_valid ##1 !resp_valid)
        else $error("response not one pulse after last cycle");
endmodule

/* testbench/bsi_mem_model.sv */
// Behavioural 16-bit static memory with a wait pin and a store per lane.
// Assumes the interface clock; address bits 7:0 pick the byte slot.
`timescale 1ns/1ns
module bsi_mem_model (
    // Clock
    input wire logic clk,
    // Bus
    input wire logic [23:0] ext_addr,
    input wire logic [15:0] data_o,
    input wire logic rd_wr,
    input wire logic upper_byte_write_n,
    input wire logic lower_byte_write_n,
    input wire logic bus_cycle_start_n,
    input wire logic [7:0] area_select_n,
    output logic [15:0] data_i,
    output logic wait_n,
    // Slowness
    input wire logic [3:0] stall
);
    logic [7:0] hi [256];
    logic [7:0] lo [256];
    logic [15:0] last = 16'h0;
    logic [3:0] cnt = 4'hf;
    logic [7:0] a;
    logic sel;
    assign a = ext_addr[7:0];
    assign sel = area_select_n == ~(8'h01 << ext_addr[23:21]);
    // Released bus shows the inverse, never a stale copy
    assign data_i = (sel && rd_wr) ? {hi[a], lo[a]} : ~last;
    // Pulled up; slow part holds it low until ready
    assign wait_n = !(sel && (!bus_cycle_start_n || cnt < stall));
    always @(posedge clk) begin
        last <= data_i;
        cnt <= bus_cycle_start_n ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
        if (sel && !rd_wr && !upper_byte_write_n) hi[a] <= data_o[15:8];
        if (sel && !rd_wr && !lower_byte_write_n) lo[a] <= data_o[7:0];
    end
endmodule

/* testbench/testbench.sv */
// Self-checking bench: AXI4-Lite setup, internal requests, memory model.
// Assumes rtl/ compiled first and bsi_defs.svh on the include path.
`timescale 1ns/1ns
`include "bsi_defs.svh"
module testbench;
    logic clk = 0, rst = 1;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rdt, rsd, q;
    logic awv = 0, awr, wv = 0, wrdy, bre = 0, bv, arv = 0, arr, rv, rre = 0;
    logic [1:0] brp, rrp, r;
    logic rqv = 0, rqr, rqw = 0, rsv, doe, bcs, asn, ahn, rdn, rdwr, ubw, lbw, wtn;
    logic [23:0] rqa = 24'h0, xa;
    logic [31:0] rqd = 32'h0;
    bsi_pkg::bsi_size_t rqs = bsi_pkg::SZ_BYTE;
    logic [15:0] dout, din;
    logic [7:0] csn;
    logic [3:0] stall = 4'h0;
    int n_errors = 0, num_checks = 0, c, as3 = 0, ah3 = 0;
    logic [7:0] ra [5] = '{`BSI_REG_BCR, `BSI_REG_AREA, `BSI_REG_WCA, `BSI_REG_WCB, `BSI_REG_IBC};
    logic [31:0] rv0 [5] = '{32'h0, 32'h0000ff00, 32'h00007777, 32'h00007777, 32'h0};
    always #5 clk = ~clk;
    bsi_top uut (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(brp), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
        .s_axi_rresp(rrp), .s_axi_rvalid(rv), .s_axi_rready(rre), .req_valid(rqv),
        .req_ready(rqr), .req_addr(rqa), .req_size(rqs), .req_write(rqw), .req_wdata(rqd),
        .resp_valid(rsv), .resp_rdata(rsd), .ext_addr(xa), .data_o(dout), .data_oe(doe),
        .data_i(din), .bus_cycle_start_n(bcs), .address_strobe_n(asn),
        .address_hold_n(ahn), .read_n(rdn), .rd_wr(rdwr), .upper_byte_write_n(ubw),
        .lower_byte_write_n(lbw), .area_select_n(csn), .wait_n(wtn));
    bsi_mem_model mdl (.clk(clk), .ext_addr(xa), .data_o(dout), .rd_wr(rdwr),
        .upper_byte_write_n(ubw), .lower_byte_write_n(lbw), .bus_cycle_start_n(bcs),
        .area_select_n(csn), .data_i(din), .wait_n(wtn), .stall(stall));
    // Strobe use inside the multiplexed area
    always @(posedge clk) begin
        if (!csn[3] && !asn) as3++;
        if (!csn[3] && !ahn) ah3++;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, s, e);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        do begin
            @(posedge clk);
            awv <= awv & ~awr;
            wv <= wv & ~wrdy;
        end while (!bv);
        bre <= 0;
        chk({30'h0, brp}, {30'h0, `BSI_RESP_OK});
    endtask
    task axr(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rre <= 1;
        do begin
            @(posedge clk);
            arv <= arv & ~arr;
        end while (!rv);
        rre <= 0;
        q = rdt;
        r = rrp;
    endtask
    // Cycle count runs from the take edge to the completion pulse
    task acc(input logic [23:0] a, input bsi_pkg::bsi_size_t s, input logic w,
            input logic [31:0] d, input int ec);
        @(posedge clk);
        rqv <= 1;
        rqa <= a;
        rqs <= s;
        rqw <= w;
        rqd <= d;
        do @(posedge clk); while (!rqr);
        rqv <= 0;
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (!rsv);
        q = rsd;
        if (ec > 0) chk(c, ec);
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        $display("watchdog expired");
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 5; i++) begin
            axr(ra[i]);
            chk(q, rv0[i]);
        end
        axr(8'h18);
        chk({30'h0, r}, {30'h0, `BSI_RESP_ERR});
        axw(`BSI_REG_STAT, 32'hffffffff);
        axr(`BSI_REG_STAT);
        chk(q, 32'h0);
        $display("test registers done");
        // Reset area: 8-bit, 3-state, seven waits
        acc(24'h000003, bsi_pkg::SZ_BYTE, 1, 32'h5a, 11);
        chk(mdl.lo[3], 8'h5a);
        $display("test reset timing done");
        axw(`BSI_REG_AREA, 32'h0408fd06);
        axw(`BSI_REG_WCB, 32'h00002077);
        // Area 1: 16-bit, 2-state, big endian
        acc(24'h200006, bsi_pkg::SZ_BYTE, 1, 32'ha5, 3);
        chk(mdl.hi[6], 8'ha5);
        acc(24'h200011, bsi_pkg::SZ_LONG, 1, 32'h11223344, 7);
        chk({mdl.lo[8'h11], mdl.hi[8'h12], mdl.lo[8'h12], mdl.hi[8'h14]}, 32'h11223344);
        acc(24'h200011, bsi_pkg::SZ_LONG, 0, 32'h0, 7);
        chk(q, 32'h11223344);
        $display("test big endian done");
        // Area 2: 16-bit, 3-state, little endian, no waits
        acc(24'h400026, bsi_pkg::SZ_BYTE, 1, 32'h3c, 4);
        chk(mdl.lo[8'h26], 8'h3c);
        acc(24'h400021, bsi_pkg::SZ_LONG, 1, 32'h11223344, 10);
        chk({mdl.lo[8'h24], mdl.hi[8'h22], mdl.lo[8'h22], mdl.hi[8'h21]}, 32'h11223344);
        acc(24'h400021, bsi_pkg::SZ_LONG, 0, 32'h0, 10);
        chk(q, 32'h11223344);
        $display("test little endian done");
        // Area 3: 8-bit, multiplexed, two waits
        acc(24'h600030, bsi_pkg::SZ_WORD, 1, 32'hbeef, 11);
        chk({mdl.lo[8'h30], mdl.lo[8'h31]}, 16'hbeef);
        chk(as3, 0);
        chk(ah3, 10);
        $display("test multiplexed done");
        // Pin wait needs both enables
        stall <= 4'h4;
        axw(`BSI_REG_BCR, 32'h1);
        acc(24'h600030, bsi_pkg::SZ_BYTE, 0, 32'h0, 6);
        axw(`BSI_REG_IBC, 32'h1);
        acc(24'h600030, bsi_pkg::SZ_BYTE, 0, 32'h0, 0);
        chk(c > 6 && c < 13, 1);
        chk({24'h0, q[7:0]}, 32'hbe);
        acc(24'h200006, bsi_pkg::SZ_BYTE, 0, 32'h0, 3);
        $display("test pin wait done");
        wrap_up;
    end
endmodule
